/* logic/process_data_mapping_checker.sv */
// Contract
// - Only mappings 1600 and 1A00 are editable.
// - Editable rx 10 objects, 24 bytes; tx 10 objects, 30 bytes.
// - Editable tx beside a second mapping: total at most 30 bytes.
// - Byte total over limit raises fault 93.4.
// - Object count over limit raises fault 93.4.
// - At most two mappings per direction, set in the assignments.
// - Slot 01 objects come before slot 02 objects.
// - A repeated rx object takes its last occurrence.
// - Mapping changes only in Pre-Operational.
// - Power-up restores default mappings.
// - Rx pair: one of 1701-1705 with 1600; at most 10 objects.
// - Tx pairs fixed+1A00, fixed+1BFF, 1A00+1BFF; at most 11 objects.
// - Aborts for toggle, timeout, unknown command.
// - Aborts for write-only read, read-only write, missing index.
// - Aborts for unmappable object and full mapping.
// - Aborts for length mismatch, too long, too short.
// - Aborts for missing sub-index, value too high, too low.
// - State-forbidden transfers abort with state code.
// - Sync0 events time the control processing.
// - Cycle is Sync0 period: 250 us, 500 us, 1, 2 or 4 ms.
// - At 250 or 500 us gear must be 1:1, else fault 93.4.
`timescale 1ns/1ns
module process_data_mapping_checker
   import process_data_mapping_pkg::*;
#(
   parameter int unsigned SYNC0_UNIT_CYCLES = SYNC0_UNIT_NS / CLK_PERIOD_NS,
   parameter logic [4:0][4:0] FIX_RX_N = {5'h08, 5'h09, 5'h07, 5'h07, 5'h07},
   parameter logic [4:0][7:0] FIX_RX_BYTES = {5{8'h10}},
   parameter logic [3:0][4:0] FIX_TX_N = {5'h09, 5'h0a, 5'h09, 5'h09},
   parameter logic [3:0][7:0] FIX_TX_BYTES = {4{8'h1c}}
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Network state requests
   input wire logic esm_req_valid,
   input wire esm_t esm_req_state,
   output esm_t esm_state,
   output logic esm_ack,
   output logic esm_refused,
   // Object access request
   input wire logic req_valid,
   input wire req_kind_t req_kind,
   input wire logic req_write,
   input wire logic [15:0] req_index,
   input wire logic [7:0] req_sub,
   input wire logic [15:0] req_value,
   input wire logic [7:0] req_obj_len,
   input wire logic req_obj_mappable,
   input wire logic req_toggle_ok,
   input wire logic req_timeout,
   input wire logic req_ccs_ok,
   input wire logic req_obj_exists,
   input wire logic req_sub_exists,
   input wire logic req_readable,
   input wire logic req_writable,
   input wire logic req_state_ok,
   input wire logic [1:0] req_len_cmp,
   input wire logic [1:0] req_range_cmp,
   // Request answer
   output logic rsp_valid,
   output logic rsp_abort,
   output logic [31:0] rsp_code,
   // Cycle setup and distributed clock
   input wire logic [2:0] cycle_sel,
   input wire logic gear_is_unity,
   input wire logic dc_sync_en,
   input wire logic dc_align,
   output logic sync0_evt,
   output logic ctrl_tick,
   // Fault report
   input wire logic fault_clr,
   output logic func_fault,
   output logic [7:0] fault_main,
   output logic [3:0] fault_sub,
   // Receive duplicate lookup
   input wire logic [15:0] rx_pick_obj,
   output logic rx_pick_hit,
   output logic [5:0] rx_pick_pos
);
   // Editable mappings, dir 0 rx, dir 1 tx
   logic [15:0] map_idx [2][MAX_EDIT_OBJS];
   logic [7:0] map_len [2][MAX_EDIT_OBJS];
   logic [4:0] map_n [2];
   logic [15:0] asn [2][2];
   logic [1:0] asn_n [2];
   logic [31:0] sync_cnt;
   logic sync_run_d;

   // Prefix byte sums
   logic [11:0] pre [2][MAX_EDIT_OBJS+1];
   logic [11:0] edit_bytes [2];
   genvar d, k, s;
   generate
      for (d = 0; d < 2; d++) begin : g_dir
         assign pre[d][0] = 12'h000;
         for (k = 0; k < MAX_EDIT_OBJS; k++) begin : g_ent
            assign pre[d][k+1] = pre[d][k] + ((5'(k) < map_n[d]) ? {4'h0, map_len[d][k]} : 12'h000);
         end
         assign edit_bytes[d] = pre[d][MAX_EDIT_OBJS];
      end
   endgenerate

   // Per-slot classification of assigned mappings
   logic [4:0] slot_objs [2][2];
   logic [7:0] slot_bytes [2][2];
   logic slot_fix [2][2], slot_edit [2][2], slot_stat [2][2], slot_used [2][2];
   generate
      for (s = 0; s < 2; s++) begin : g_slot
         wire [2:0] rx_off = 3'(asn[0][s] - IDX_RX_FIX_LO);
         wire [1:0] tx_off = 2'(asn[1][s] - IDX_TX_FIX_LO);
         assign slot_used[0][s] = 2'(s) < asn_n[0];
         assign slot_used[1][s] = 2'(s) < asn_n[1];
         assign slot_fix[0][s] = asn[0][s] >= IDX_RX_FIX_LO && asn[0][s] <= IDX_RX_FIX_HI;
         assign slot_fix[1][s] = asn[1][s] >= IDX_TX_FIX_LO && asn[1][s] <= IDX_TX_FIX_HI;
         assign slot_edit[0][s] = asn[0][s] == IDX_RX_EDIT;
         assign slot_edit[1][s] = asn[1][s] == IDX_TX_EDIT;
         assign slot_stat[0][s] = 1'b0;
         assign slot_stat[1][s] = asn[1][s] == IDX_TX_STATUS;
         assign slot_objs[0][s] = !slot_used[0][s] ? 5'h00 : slot_edit[0][s] ? map_n[0] :
            slot_fix[0][s] ? FIX_RX_N[rx_off] : 5'h00;
         assign slot_bytes[0][s] = !slot_used[0][s] ? 8'h00 : slot_edit[0][s] ? edit_bytes[0][7:0] :
            slot_fix[0][s] ? FIX_RX_BYTES[rx_off] : 8'h00;
         assign slot_objs[1][s] = !slot_used[1][s] ? 5'h00 : slot_edit[1][s] ? map_n[1] :
            slot_fix[1][s] ? FIX_TX_N[tx_off] : slot_stat[1][s] ? STATUS_MAP_OBJS : 5'h00;
         assign slot_bytes[1][s] = !slot_used[1][s] ? 8'h00 : slot_edit[1][s] ? edit_bytes[1][7:0] :
            slot_fix[1][s] ? FIX_TX_BYTES[tx_off] : slot_stat[1][s] ? STATUS_MAP_BYTES : 8'h00;
      end
   endgenerate

   wire one_rx = asn_n[0] == 2'h1;
   wire two_rx = asn_n[0] == MAX_ASSIGNED;
   wire one_tx = asn_n[1] == 2'h1;
   wire two_tx = asn_n[1] == MAX_ASSIGNED;
   wire rx_combo_ok = (one_rx && (slot_fix[0][0] || slot_edit[0][0])) ||
      (two_rx && ((slot_fix[0][0] && slot_edit[0][1]) || (slot_edit[0][0] && slot_fix[0][1])));
   wire tx_pair_fe = (slot_fix[1][0] && slot_edit[1][1]) || (slot_edit[1][0] && slot_fix[1][1]);
   wire tx_pair_fs = (slot_fix[1][0] && slot_stat[1][1]) || (slot_stat[1][0] && slot_fix[1][1]);
   wire tx_pair_es = (slot_edit[1][0] && slot_stat[1][1]) || (slot_stat[1][0] && slot_edit[1][1]);
   wire tx_combo_ok = (one_tx && (slot_fix[1][0] || slot_edit[1][0] || slot_stat[1][0])) ||
      (two_tx && (tx_pair_fe || tx_pair_fs || tx_pair_es));
   wire [5:0] rx_tot_objs = {1'b0, slot_objs[0][0]} + {1'b0, slot_objs[0][1]};
   wire [5:0] tx_tot_objs = {1'b0, slot_objs[1][0]} + {1'b0, slot_objs[1][1]};
   wire [11:0] tx_tot_bytes = {4'h0, slot_bytes[1][0]} + {4'h0, slot_bytes[1][1]};
   wire tx_edit_used = (slot_used[1][0] && slot_edit[1][0]) || (slot_used[1][1] && slot_edit[1][1]);
   wire count_ok = rx_tot_objs <= RX_MAX_TOTAL_OBJS && tx_tot_objs <= TX_MAX_TOTAL_OBJS &&
      map_n[0] <= 5'(MAX_EDIT_OBJS) && map_n[1] <= 5'(MAX_EDIT_OBJS);
   wire size_ok = edit_bytes[0] <= RX_MAX_BYTES && edit_bytes[1] <= TX_MAX_BYTES &&
      !(two_tx && tx_edit_used && tx_tot_bytes > TX_MAX_BYTES);
   // cycle range; gear at short cycles
   wire cycle_ok = cycle_sel <= CYC_SEL_MAX;
   wire gear_ok = cycle_sel > CYC_500US || gear_is_unity;
   wire setup_ok = count_ok && size_ok && cycle_ok && gear_ok;
   wire combo_ok = rx_combo_ok && tx_combo_ok;

   // transition screen; limit failures raise fault
   wire leave_preop = esm_state == ESM_PREOP && (esm_req_state == ESM_SAFEOP || esm_req_state == ESM_OP);
   wire up_from_safe = esm_state == ESM_SAFEOP && esm_req_state == ESM_OP;
   wire down_req = esm_req_state == ESM_INIT || esm_req_state == ESM_PREOP || esm_req_state == esm_state;
   wire trans_ok = down_req || up_from_safe || (leave_preop && setup_ok && combo_ok);
   wire fault_set = esm_req_valid && leave_preop && !setup_ok;

   // Request decode
   wire is_preop = esm_state == ESM_PREOP;
   wire is_map = req_kind == REQ_MAP_ENTRY || req_kind == REQ_MAP_COUNT;
   wire map_dir = req_index == IDX_TX_EDIT || req_index[15:8] == IDX_TX_FIX_LO[15:8];
   wire asn_dir = req_index == IDX_TX_ASSIGN;
   wire req_dir = is_map ? map_dir : asn_dir;
   wire map_edit = req_index == IDX_RX_EDIT || req_index == IDX_TX_EDIT;
   wire map_fixed = (req_index >= IDX_RX_FIX_LO && req_index <= IDX_RX_FIX_HI) ||
      (req_index >= IDX_TX_FIX_LO && req_index <= IDX_TX_FIX_HI) || req_index == IDX_TX_STATUS;
   wire asn_known = req_index == IDX_RX_ASSIGN || req_index == IDX_TX_ASSIGN;
   wire cfg_known = is_map ? (map_edit || map_fixed) : asn_known;
   wire [3:0] ent_sel = 4'(req_sub - 8'h01);
   wire sub_in_map = req_sub != 8'h00 && req_sub <= 8'(MAX_EDIT_OBJS);
   wire ent_live = 5'(ent_sel) < map_n[req_dir];
   wire [11:0] old_len = ent_live ? {4'h0, map_len[req_dir][ent_sel]} : 12'h000;
   wire [11:0] new_len = ent_live ? {4'h0, req_obj_len} : 12'h000;
   wire [11:0] dir_cap = req_dir ? TX_MAX_BYTES : RX_MAX_BYTES;
   wire [11:0] ent_bytes = edit_bytes[req_dir] - old_len + new_len;
   wire cnt_over = req_value > 16'(MAX_EDIT_OBJS);
   wire [11:0] cnt_bytes = pre[req_dir][cnt_over ? MAX_EDIT_OBJS : int'(req_value[3:0])];
   wire asn_val_ok = req_value == 16'h0000 || (asn_dir ?
      ((req_value >= IDX_TX_FIX_LO && req_value <= IDX_TX_FIX_HI) || req_value == IDX_TX_EDIT ||
      req_value == IDX_TX_STATUS) :
      ((req_value >= IDX_RX_FIX_LO && req_value <= IDX_RX_FIX_HI) || req_value == IDX_RX_EDIT));

   wire [31:0] entry_code = !sub_in_map ? ABORT_NO_SUB : !req_obj_mappable ? ABORT_NOT_MAPPABLE :
      ent_bytes > dir_cap ? ABORT_MAP_FULL : ABORT_NONE;
   wire [31:0] count_code = (cnt_over || cnt_bytes > dir_cap) ? ABORT_MAP_FULL : ABORT_NONE;
   wire [31:0] asn_code = req_sub > 8'h02 ? ABORT_NO_SUB :
      req_sub == 8'h00 ? (req_value > 16'(MAX_ASSIGNED) ? ABORT_VAL_HIGH : ABORT_NONE) :
      !asn_val_ok ? ABORT_RANGE : ABORT_NONE;
   wire [31:0] kind_code = req_kind == REQ_MAP_ENTRY ? entry_code :
      req_kind == REQ_MAP_COUNT ? count_code : asn_code;
   // fixed read-only; edits only in Pre-Op
   wire [31:0] cfg_code = !cfg_known ? ABORT_NO_OBJECT : !req_write ? ABORT_NONE :
      (is_map && !map_edit) ? ABORT_READ_ONLY : !is_preop ? ABORT_STATE : kind_code;
   wire [31:0] gen_code = !req_obj_exists ? ABORT_NO_OBJECT : !req_sub_exists ? ABORT_NO_SUB :
      (!req_write && !req_readable) ? ABORT_WRITE_ONLY : (req_write && !req_writable) ? ABORT_READ_ONLY :
      !req_state_ok ? ABORT_STATE :
      req_len_cmp == CMP_MISMATCH ? ABORT_LEN_MISMATCH : req_len_cmp == CMP_HIGH ? ABORT_LEN_HIGH :
      req_len_cmp == CMP_LOW ? ABORT_LEN_LOW :
      (req_write && req_range_cmp == CMP_HIGH) ? ABORT_VAL_HIGH :
      (req_write && req_range_cmp == CMP_LOW) ? ABORT_VAL_LOW : ABORT_NONE;
   wire [31:0] next_code = req_timeout ? ABORT_TIMEOUT : !req_ccs_ok ? ABORT_BAD_CMD :
      !req_toggle_ok ? ABORT_TOGGLE : req_kind == REQ_GENERIC ? gen_code : cfg_code;
   wire cfg_wr = req_valid && req_write && req_kind != REQ_GENERIC && next_code == ABORT_NONE;

   // Network state
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         esm_state <= ESM_INIT;
         esm_ack <= 1'b0;
         esm_refused <= 1'b0;
      end else begin
         esm_ack <= esm_req_valid && trans_ok;
         esm_refused <= esm_req_valid && !trans_ok;
         if (esm_req_valid && trans_ok) begin
            esm_state <= esm_req_state;
         end
      end
   end

   // sticky fault; set wins over clear
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         func_fault <= 1'b0;
         fault_main <= 8'h00;
         fault_sub <= 4'h0;
      end else if (fault_set) begin
         func_fault <= 1'b1;
         fault_main <= FAULT_MAIN;
         fault_sub <= FAULT_SUB;
      end else if (fault_clr) begin
         func_fault <= 1'b0;
         fault_main <= 8'h00;
         fault_sub <= 4'h0;
      end
   end

   // Answer one cycle after request
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_abort <= 1'b0;
         rsp_code <= ABORT_NONE;
      end else begin
         rsp_valid <= req_valid;
         rsp_abort <= req_valid && next_code != ABORT_NONE;
         rsp_code <= req_valid ? next_code : ABORT_NONE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         for (int i = 0; i < MAX_EDIT_OBJS; i++) begin
            map_idx[0][i] <= RX_DEF_IDX[i];
            map_len[0][i] <= RX_DEF_LEN[i];
            map_idx[1][i] <= TX_DEF_IDX[i];
            map_len[1][i] <= TX_DEF_LEN[i];
         end
         map_n[0] <= RX_DEF_N;
         map_n[1] <= TX_DEF_N;
         asn[0][0] <= IDX_RX_FIX_LO;
         asn[0][1] <= 16'h0000;
         asn[1][0] <= IDX_TX_FIX_LO;
         asn[1][1] <= 16'h0000;
         asn_n[0] <= 2'h1;
         asn_n[1] <= 2'h1;
      end else if (cfg_wr) begin
         if (req_kind == REQ_MAP_ENTRY) begin
            map_idx[req_dir][ent_sel] <= req_value;
            map_len[req_dir][ent_sel] <= req_obj_len;
         end else if (req_kind == REQ_MAP_COUNT) begin
            map_n[req_dir] <= req_value[4:0];
         end else if (req_sub == 8'h00) begin
            asn_n[req_dir] <= req_value[1:0];
         end else begin
            asn[req_dir][req_sub[1]] <= req_value;
         end
      end
   end

   // last occurrence wins; slot 01 first
   logic last_hit;
   logic [3:0] last_ent;
   always_comb begin
      last_hit = 1'b0;
      last_ent = 4'h0;
      for (int i = 0; i < MAX_EDIT_OBJS; i++) begin
         if (5'(i) < map_n[0] && map_idx[0][i] == rx_pick_obj) begin
            last_hit = 1'b1;
            last_ent = 4'(i);
         end
      end
   end
   wire edit_in_second = slot_used[0][1] && slot_edit[0][1];
   wire edit_assigned = (slot_used[0][0] && slot_edit[0][0]) || edit_in_second;
   wire [5:0] edit_base = edit_in_second ? {1'b0, slot_objs[0][0]} : 6'h00;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rx_pick_hit <= 1'b0;
         rx_pick_pos <= 6'h00;
      end else begin
         rx_pick_hit <= last_hit && edit_assigned;
         rx_pick_pos <= edit_base + {2'h0, last_ent};
      end
   end

   // Sync0 timing; period doubles per step
   wire sync_run = dc_sync_en && cycle_ok && (esm_state == ESM_SAFEOP || esm_state == ESM_OP);
   wire [31:0] sync_period = 32'(SYNC0_UNIT_CYCLES) << cycle_sel;
   wire sync_wrap = sync_cnt >= sync_period - 32'h1;
   // Restart on enable or align; first event a full period later
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sync_cnt <= 32'h0;
         sync_run_d <= 1'b0;
         sync0_evt <= 1'b0;
         ctrl_tick <= 1'b0;
      end else begin
         sync_run_d <= sync_run;
         sync0_evt <= sync_run && sync_run_d && !dc_align && sync_wrap;
         ctrl_tick <= sync0_evt;
         if (!sync_run || !sync_run_d || dc_align || sync_wrap) begin
            sync_cnt <= 32'h0;
         end else begin
            sync_cnt <= sync_cnt + 32'h1;
         end
      end
   end
endmodule : process_data_mapping_checker

/* logic/process_data_mapping_pkg.sv */
package process_data_mapping_pkg;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SYNC0_UNIT_NS = 250000;
   // Object indices
   localparam logic [15:0] IDX_RX_EDIT = 16'h1600;
   localparam logic [15:0] IDX_TX_EDIT = 16'h1a00;
   localparam logic [15:0] IDX_RX_FIX_LO = 16'h1701;
   localparam logic [15:0] IDX_RX_FIX_HI = 16'h1705;
   localparam logic [15:0] IDX_TX_FIX_LO = 16'h1b01;
   localparam logic [15:0] IDX_TX_FIX_HI = 16'h1b04;
   localparam logic [15:0] IDX_TX_STATUS = 16'h1bff;
   localparam logic [15:0] IDX_RX_ASSIGN = 16'h1c12;
   localparam logic [15:0] IDX_TX_ASSIGN = 16'h1c13;
   // Capacity limits
   localparam int MAX_EDIT_OBJS = 10;
   localparam logic [11:0] RX_MAX_BYTES = 12'h018;
   localparam logic [11:0] TX_MAX_BYTES = 12'h01e;
   localparam logic [5:0] RX_MAX_TOTAL_OBJS = 6'h0a;
   localparam logic [5:0] TX_MAX_TOTAL_OBJS = 6'h0b;
   localparam logic [1:0] MAX_ASSIGNED = 2'h2;
   localparam logic [4:0] STATUS_MAP_OBJS = 5'h01;
   localparam logic [7:0] STATUS_MAP_BYTES = 8'h01;
   // Function-setting fault number
   localparam logic [7:0] FAULT_MAIN = 8'h5d;
   localparam logic [3:0] FAULT_SUB = 4'h4;
   // Service data abort codes
   localparam logic [31:0] ABORT_NONE = 32'h0000_0000;
   localparam logic [31:0] ABORT_TOGGLE = 32'h0503_0000;
   localparam logic [31:0] ABORT_TIMEOUT = 32'h0504_0000;
   localparam logic [31:0] ABORT_BAD_CMD = 32'h0504_0001;
   localparam logic [31:0] ABORT_WRITE_ONLY = 32'h0601_0001;
   localparam logic [31:0] ABORT_READ_ONLY = 32'h0601_0002;
   localparam logic [31:0] ABORT_NO_OBJECT = 32'h0602_0000;
   localparam logic [31:0] ABORT_NOT_MAPPABLE = 32'h0604_0041;
   localparam logic [31:0] ABORT_MAP_FULL = 32'h0604_0042;
   localparam logic [31:0] ABORT_LEN_MISMATCH = 32'h0607_0010;
   localparam logic [31:0] ABORT_LEN_HIGH = 32'h0607_0012;
   localparam logic [31:0] ABORT_LEN_LOW = 32'h0607_0013;
   localparam logic [31:0] ABORT_NO_SUB = 32'h0609_0011;
   localparam logic [31:0] ABORT_RANGE = 32'h0609_0030;
   localparam logic [31:0] ABORT_VAL_HIGH = 32'h0609_0031;
   localparam logic [31:0] ABORT_VAL_LOW = 32'h0609_0032;
   localparam logic [31:0] ABORT_STATE = 32'h0800_0022;
   // Length and value compare codes
   localparam logic [1:0] CMP_OK = 2'h0;
   localparam logic [1:0] CMP_MISMATCH = 2'h1;
   localparam logic [1:0] CMP_HIGH = 2'h2;
   localparam logic [1:0] CMP_LOW = 2'h3;
   // Cycle selections
   localparam logic [2:0] CYC_500US = 3'h1;
   localparam logic [2:0] CYC_SEL_MAX = 3'h4;
   // Default editable mappings
   localparam logic [4:0] RX_DEF_N = 5'h03;
   localparam logic [4:0] TX_DEF_N = 5'h07;
   localparam logic [9:0][15:0] RX_DEF_IDX = {112'h0, 16'h60b8, 16'h607a, 16'h6040};
   localparam logic [9:0][7:0] RX_DEF_LEN = {56'h0, 8'h02, 8'h04, 8'h02};
   localparam logic [9:0][15:0] TX_DEF_IDX = {48'h0, 16'h60fd, 16'h60bc, 16'h60ba, 16'h60b9,
      16'h6064, 16'h6041, 16'h603f};
   localparam logic [9:0][7:0] TX_DEF_LEN = {24'h0, 8'h04, 8'h04, 8'h04, 8'h02, 8'h04, 8'h02, 8'h02};

   typedef enum logic [1:0] {ESM_INIT, ESM_PREOP, ESM_SAFEOP, ESM_OP} esm_t;
   typedef enum logic [1:0] {REQ_GENERIC, REQ_MAP_ENTRY, REQ_MAP_COUNT, REQ_ASSIGN} req_kind_t;
endpackage : process_data_mapping_pkg

/* verification/pdm_checker_asserts.sv */
`timescale 1ns/1ns
module pdm_checker_asserts
   import process_data_mapping_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Requests seen by the block
   input wire logic req_valid, req_timeout, esm_req_valid, gear_is_unity,
   input wire esm_t esm_req_state,
   input wire logic [2:0] cycle_sel,
   // Answers of the block
   input wire esm_t esm_state,
   input wire logic esm_ack, esm_refused, rsp_valid, rsp_abort, sync0_evt, ctrl_tick, func_fault,
   input wire logic [31:0] rsp_code,
   input wire logic [7:0] fault_main,
   input wire logic [3:0] fault_sub
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Answer timing
   a_rsp_one_cycle: assert property (req_valid |=> rsp_valid) else $error("request not answered");
   a_rsp_no_spurious: assert property (!req_valid |=> !rsp_valid) else $error("answer without request");
   a_code_idle_zero: assert property (!rsp_valid |-> rsp_code == ABORT_NONE) else $error("stale code");
   a_timeout_code_first: assert property (req_valid && req_timeout |=> rsp_abort && rsp_code == ABORT_TIMEOUT)
      else $error("timeout code wrong");
   // State change, fault and tick answers
   a_esm_one_answer: assert property (esm_req_valid |=> esm_ack != esm_refused) else $error("bad state answer");
   a_init_to_op: assert property (esm_req_valid && esm_state == ESM_INIT && esm_req_state == ESM_OP
      |=> esm_refused && esm_state == ESM_INIT) else $error("init to op taken");
   a_fault_number: assert property (func_fault |-> fault_main == FAULT_MAIN && fault_sub == FAULT_SUB)
      else $error("fault number wrong");
   a_gear_fault_raise: assert property (esm_req_valid && esm_state == ESM_PREOP && esm_req_state == ESM_SAFEOP
      && cycle_sel <= 3'h1 && !gear_is_unity |=> esm_refused && func_fault) else $error("gear check missed");
   a_tick_after_sync: assert property (sync0_evt |=> ctrl_tick) else $error("no control tick");
   // Scenarios
   c_ack: cover property (esm_req_valid ##1 esm_ack);
   c_abort: cover property (rsp_abort);
   c_sync: cover property (sync0_evt);
endmodule : pdm_checker_asserts
bind process_data_mapping_checker pdm_checker_asserts chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
   .req_valid(req_valid), .req_timeout(req_timeout), .esm_req_valid(esm_req_valid), .gear_is_unity(gear_is_unity),
   .esm_req_state(esm_req_state), .cycle_sel(cycle_sel), .esm_state(esm_state), .esm_ack(esm_ack),
   .esm_refused(esm_refused), .rsp_valid(rsp_valid), .rsp_abort(rsp_abort), .sync0_evt(sync0_evt),
   .ctrl_tick(ctrl_tick), .func_fault(func_fault), .rsp_code(rsp_code), .fault_main(fault_main),
   .fault_sub(fault_sub));

/* verification/ecat_master_model.sv */
`timescale 1ns/1ns
module ecat_master_model
   import process_data_mapping_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // State requests and cycle setup
   output logic esm_req_valid,
   output esm_t esm_req_state,
   output logic [2:0] cycle_sel,
   output logic dc_sync_en
);
   initial begin
      esm_req_valid = 1'b0;
      esm_req_state = ESM_INIT;
      cycle_sel = 3'h0;
      dc_sync_en = 1'b1;
   end
   task go(input esm_t s);
      @(negedge clk_sys);
      esm_req_valid = 1'b1;
      esm_req_state = s;
      @(negedge clk_sys);
      esm_req_valid = 1'b0;
   endtask : go
   task cyc(input logic [2:0] sel);
      @(negedge clk_sys);
      cycle_sel = (sel > CYC_SEL_MAX) ? CYC_SEL_MAX : sel;
   endtask : cyc
endmodule : ecat_master_model

/* verification/tb.sv */
`timescale 1ns/1ns
module tb;
   import process_data_mapping_pkg::*;
   localparam logic [12:0] OK = 13'h0ff0;
   localparam logic [12:0] GM [14] = '{13'h1000, 13'h1c00, 13'h0c00, 13'h0800, 13'h0200, 13'h0100, 13'h0080,
      13'h0040, 13'h0020, 13'h0004, 13'h0008, 13'h000c, 13'h0002, 13'h0003};
   localparam logic [31:0] GC [14] = '{ABORT_TIMEOUT, ABORT_TIMEOUT, ABORT_BAD_CMD, ABORT_TOGGLE, ABORT_NO_OBJECT,
      ABORT_NO_SUB, ABORT_WRITE_ONLY, ABORT_READ_ONLY, ABORT_STATE, ABORT_LEN_MISMATCH, ABORT_LEN_HIGH,
      ABORT_LEN_LOW, ABORT_VAL_HIGH, ABORT_VAL_LOW};
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0, req_write = 1'b0, dc_align = 1'b0, fault_clr = 1'b0, gear_is_unity = 1'b1;
   req_kind_t req_kind = REQ_GENERIC;
   logic [15:0] req_index = 16'h0, req_value = 16'h0, rx_pick_obj = 16'h0;
   logic [7:0] req_sub = 8'h0, req_obj_len = 8'h0;
   logic [12:0] flg = OK; // Attribute flags, see port map
   esm_t esm_req_state, esm_state;
   logic esm_req_valid, esm_ack, esm_refused, rsp_valid, rsp_abort, sync0_evt, ctrl_tick, func_fault, rx_pick_hit;
   logic dc_sync_en;
   logic [2:0] cycle_sel;
   logic [31:0] rsp_code;
   logic [7:0] fault_main;
   logic [3:0] fault_sub;
   logic [5:0] rx_pick_pos;
   int n_fail = 0;
   int cmp_count = 0;
   int n;
   always #5 clk_sys = ~clk_sys;
   // Short Sync0 unit keeps the run brief
   process_data_mapping_checker #(.SYNC0_UNIT_CYCLES(4)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
      .esm_req_valid(esm_req_valid), .esm_req_state(esm_req_state), .esm_state(esm_state), .esm_ack(esm_ack),
      .esm_refused(esm_refused), .req_valid(req_valid), .req_kind(req_kind), .req_write(req_write),
      .req_index(req_index), .req_sub(req_sub), .req_value(req_value), .req_obj_len(req_obj_len),
      .req_obj_mappable(flg[4]), .req_toggle_ok(flg[11]), .req_timeout(flg[12]), .req_ccs_ok(flg[10]),
      .req_obj_exists(flg[9]), .req_sub_exists(flg[8]), .req_readable(flg[7]), .req_writable(flg[6]),
      .req_state_ok(flg[5]), .req_len_cmp(flg[3:2]), .req_range_cmp(flg[1:0]), .rsp_valid(rsp_valid),
      .rsp_abort(rsp_abort), .rsp_code(rsp_code), .cycle_sel(cycle_sel), .gear_is_unity(gear_is_unity),
      .dc_sync_en(dc_sync_en), .dc_align(dc_align), .sync0_evt(sync0_evt), .ctrl_tick(ctrl_tick),
      .fault_clr(fault_clr), .func_fault(func_fault), .fault_main(fault_main), .fault_sub(fault_sub),
      .rx_pick_obj(rx_pick_obj), .rx_pick_hit(rx_pick_hit), .rx_pick_pos(rx_pick_pos));
   ecat_master_model m_u (.clk_sys(clk_sys), .esm_req_valid(esm_req_valid), .esm_req_state(esm_req_state),
      .cycle_sel(cycle_sel), .dc_sync_en(dc_sync_en));
   task end_sim;
      if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Request, answer judged next cycle
   task rq(input req_kind_t k, input logic [15:0] ix, input logic [7:0] sb, input logic [15:0] v, input logic [31:0] e,
      input logic [7:0] ln = 8'h0, input logic [12:0] f = OK, input logic w = 1'b1);
      @(negedge clk_sys);
      {req_valid, req_kind, req_write, req_index, req_sub, req_value, req_obj_len, flg} = {1'b1, k, w, ix, sb, v, ln, f};
      @(negedge clk_sys);
      req_valid = 1'b0;
      chk("rsp", {rsp_valid, rsp_abort, rsp_code}, {1'b1, e != 32'h0, e});
   endtask : rq
   task st(input esm_t s, input logic a, input logic f, input esm_t es);
      m_u.go(s);
      chk("esm", 34'({esm_ack, esm_refused, func_fault, fault_main, esm_state}), 34'({a, !a, f, f ? FAULT_MAIN : 8'h00, es}));
   endtask : st
   task pk(input logic [15:0] o, input logic [6:0] e);
      @(negedge clk_sys);
      rx_pick_obj = o;
      @(negedge clk_sys);
      chk("pick", 34'({rx_pick_hit, rx_pick_pos}), 34'(e));
   endtask : pk
   task fc;
      @(negedge clk_sys);
      fault_clr = 1'b1;
      @(negedge clk_sys);
      fault_clr = 1'b0;
      chk("fault_clr", 34'(func_fault), 34'h0);
   endtask : fc
   task wt(output int c);
      c = 0;
      do begin
         @(negedge clk_sys);
         c++;
      end while (sync0_evt !== 1'b1 && c < 300);
      if (c >= 300) begin
         n_fail++;
         end_sim();
      end
   endtask : wt
   task t_generic;
      for (int i = 0; i < 14; i++) rq(REQ_GENERIC, 16'h2000, 8'h01, 16'h0, GC[i], 8'h0, OK ^ GM[i], i != 6);
   endtask : t_generic
   task t_map;
      chk("reset_state", 34'({esm_state, func_fault}), 34'({ESM_INIT, 1'b0}));
      pk(16'h60b8, 7'h02);
      rq(REQ_MAP_ENTRY, IDX_RX_EDIT, 8'h01, 16'h6040, ABORT_STATE, 8'h02);
      st(ESM_PREOP, 1'b1, 1'b0, ESM_PREOP);
      rq(REQ_ASSIGN, IDX_RX_ASSIGN, 8'h00, 16'h0003, ABORT_VAL_HIGH);
      rq(REQ_ASSIGN, IDX_RX_ASSIGN, 8'h03, 16'h1600, ABORT_NO_SUB);
      rq(REQ_ASSIGN, IDX_RX_ASSIGN, 8'h02, IDX_TX_FIX_LO, ABORT_RANGE);
      rq(REQ_ASSIGN, IDX_RX_ASSIGN, 8'h02, IDX_RX_EDIT, ABORT_NONE);
      rq(REQ_ASSIGN, IDX_RX_ASSIGN, 8'h00, 16'h0002, ABORT_NONE);
      rq(REQ_MAP_ENTRY, IDX_RX_FIX_LO, 8'h01, 16'h6040, ABORT_READ_ONLY, 8'h02);
      rq(REQ_MAP_ENTRY, 16'h1800, 8'h01, 16'h6040, ABORT_NO_OBJECT, 8'h02);
      rq(REQ_MAP_ENTRY, IDX_RX_EDIT, 8'h0b, 16'h6040, ABORT_NO_SUB, 8'h02);
      rq(REQ_MAP_ENTRY, IDX_RX_EDIT, 8'h01, 16'h6040, ABORT_NOT_MAPPABLE, 8'h02, OK ^ 13'h0010);
      rq(REQ_MAP_ENTRY, IDX_RX_EDIT, 8'h01, 16'h6040, ABORT_MAP_FULL, 8'h13);
      rq(REQ_MAP_ENTRY, IDX_RX_EDIT, 8'h01, 16'h6040, ABORT_NONE, 8'h12);
      rq(REQ_MAP_ENTRY, IDX_RX_EDIT, 8'h01, 16'h6040, ABORT_NONE, 8'h02);
      rq(REQ_MAP_COUNT, IDX_RX_EDIT, 8'h00, 16'h000b, ABORT_MAP_FULL);
      rq(REQ_MAP_ENTRY, IDX_RX_EDIT, 8'h04, 16'h607a, ABORT_NONE, 8'h04);
      rq(REQ_MAP_COUNT, IDX_RX_EDIT, 8'h00, 16'h0004, ABORT_NONE);
      pk(16'h607a, 7'h4a);
      pk(16'h60b8, 7'h49);
      st(ESM_SAFEOP, 1'b0, 1'b1, ESM_PREOP);
      rq(REQ_MAP_COUNT, IDX_RX_EDIT, 8'h00, 16'h0003, ABORT_NONE);
      fc();
      st(ESM_SAFEOP, 1'b1, 1'b0, ESM_SAFEOP);
      rq(REQ_MAP_ENTRY, IDX_RX_EDIT, 8'h01, 16'h6040, ABORT_STATE, 8'h02);
   endtask : t_map
   // Sync0 spacing per cycle choice after realign
   task t_sync;
      for (int s = 0; s < 5; s++) begin
         m_u.cyc(3'(s));
         @(negedge clk_sys);
         dc_align = 1'b1;
         @(negedge clk_sys);
         dc_align = 1'b0;
         repeat (3) wt(n);
         chk("sync_period", 34'(n), 34'(4 << s));
      end
   endtask : t_sync
   task t_gear;
      st(ESM_PREOP, 1'b1, 1'b0, ESM_PREOP);
      m_u.cyc(CYC_500US);
      gear_is_unity = 1'b0;
      st(ESM_SAFEOP, 1'b0, 1'b1, ESM_PREOP);
      gear_is_unity = 1'b1;
      fc();
      st(ESM_INIT, 1'b1, 1'b0, ESM_INIT);
      st(ESM_OP, 1'b0, 1'b0, ESM_INIT);
   endtask : t_gear
   initial begin
      repeat (8) @(negedge clk_sys);
      rst_n = 1'b1;
      t_generic();
      t_map();
      t_sync();
      t_gear();
      end_sim();
   end
endmodule : tb
